// [epw_core.sv]
// Serial EEPROM page write, write latch and busy polling core
// Contract
// R01: Up to 8 bytes of one row are programmed in one internal cycle.
// R02: Shorter pages program only the bytes actually received.
// R03: Each data byte advances only the low three address bits.
// R04: Upper address bits stay fixed, keeping the row for the sequence.
// R05: Past the row end the column wraps to the row start.
// R06: The master should not overrun the row, wrapping overwrites loaded bytes.
// R07: Finishing the internal cycle clears the write enable latch.
// R08: The cycle starts on chip select rising after a complete valid write.
// R09: Status bit 0 reads 1 while busy and 0 when done.
// R10: While busy only the status read is executed, all else ignored.
// R11: The master polls status until bit 0 reads 0 before new commands.
// R12: A write is code 02h with ninth address bit, address, then data.
// R13: Write enable code 06h in its own frame sets the latch at deselect.
// R14: Protect pin low or latch clear discards the write at deselect.
// R15: The master must only address locations outside the protected range.
// R16: Busy lasts a bounded configurable cycle count standing for the write time.
`timescale 1ns/1ps
module epw_core #(
   parameter int WRITE_CYCLES = epw_pkg::WRITE_CYCLE_CYCLES
) (
   input  wire logic                       ref_clk,
   input  wire logic                       rst_n,
   input  wire logic                       sck,
   input  wire logic                       cs_n,
   input  wire logic                       si,
   input  wire logic                       wp_n,
   input  wire logic [1:0]                 block_protect_level,
   input  wire logic [epw_pkg::ADDR_W-1:0] mem_rd_addr,
   output logic                            so,
   output logic                            so_oe,
   output logic                            ready_busy_flag,
   output logic                            write_enable_latch,
   output logic      [7:0]                 mem_rd_data
);

   // ---------------- Link domain (serial clock) ----------------
   logic                         frame_rst_n;
   logic                         in_frame;
   logic [2:0]                   bit_cnt;
   logic [7:0]                   shift;
   logic [7:0]                   next_shift;
   logic                         byte_done;
   logic [1:0]                   byte_idx;
   logic                         link_aligned;
   logic [7:0]                   link_op;
   logic                         link_blocked;
   logic                         op_tog;
   logic [epw_pkg::ROW_W-1:0]    link_row;
   logic [epw_pkg::COL_W-1:0]    col;
   logic [7:0]                   page_buf [epw_pkg::PAGE_BYTES];
   logic [epw_pkg::PAGE_BYTES-1:0] page_mask;
   logic                         data_seen;
   logic                         status_read_cmd_active;
   logic [7:0]                   out_shift;
   logic [3:0]                   status_s;

   // Deselect clears the per-frame bit position and output drive
   assign frame_rst_n = rst_n & ~cs_n;
   assign next_shift  = {shift[6:0], si};
   assign byte_done   = (bit_cnt == 3'h7);

   // Busy, latch and protect level brought into the link domain
   epw_sync3 #(
      .WIDTH (4),
      .INIT  (epw_pkg::STAT_SYNC_INIT)
   ) u_stat_sync (
      .clk   (sck),
      .rst_n (rst_n),
      .d     ({block_protect_level, write_enable_latch, ready_busy_flag}),
      .q     (status_s)
   );

   // Bit position within the current frame
   always_ff @(posedge sck or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         in_frame <= 1'b0;
         bit_cnt  <= 3'h0;
      end else begin
         in_frame <= 1'b1;
         bit_cnt  <= bit_cnt + 3'h1;
      end
   end

   // Serial input shifter and byte alignment marker
   always_ff @(posedge sck or negedge rst_n) begin
      if (!rst_n) begin
         shift        <= 8'h00;
         link_aligned <= 1'b0;
      end else begin
         shift        <= next_shift;
         link_aligned <= byte_done;  // Frame ending now holds whole bytes
      end
   end

   // Byte index: opcode, address, then data (saturates)
   always_ff @(posedge sck or negedge rst_n) begin
      if (!rst_n) begin
         byte_idx <= 2'h0;
      end else if (!in_frame) begin
         byte_idx <= 2'h0;
      end else if (byte_done && byte_idx != 2'h2) begin
         byte_idx <= byte_idx + 2'h1;
      end
   end

   // Opcode capture and busy gating
   always_ff @(posedge sck or negedge rst_n) begin
      if (!rst_n) begin
         link_op      <= 8'h00;
         link_blocked <= 1'b0;
         op_tog       <= 1'b0;
      end else if (byte_done && byte_idx == 2'h0) begin
         link_op <= next_shift;
         // R10 ignore when busy
         link_blocked <= status_s[epw_pkg::STATUS_BUSY_BIT] &&
                         (next_shift != epw_pkg::OP_STATUS_READ);
         op_tog <= ~op_tog;  // Marks a fresh frame for the other domain
      end
   end

   // Address capture and page loading
   always_ff @(posedge sck or negedge rst_n) begin
      if (!rst_n) begin
         link_row  <= '0;
         col       <= '0;
         page_mask <= '0;
         data_seen <= 1'b0;
      end else if (byte_done && byte_idx == 2'h0) begin
         page_mask <= '0;
         data_seen <= 1'b0;
      end else if (byte_done && byte_idx == 2'h1) begin
         // R12 ninth address bit rides in the opcode
         // R04 row latched once per sequence
         link_row <= {link_op[epw_pkg::OP_A8_POS], next_shift[7:epw_pkg::COL_W]};
         col      <= next_shift[epw_pkg::COL_W-1:0];
      end else if (byte_done && byte_idx == 2'h2 && !link_blocked) begin
         // R02 mark each received byte
         page_mask[col] <= 1'b1;
         data_seen      <= 1'b1;
         // R03 low bits advance
         // R05 wraps within the row
         col <= col + 3'h1;
      end
   end

   // Page buffer, one entry per column
   for (genvar i = 0; i < epw_pkg::PAGE_BYTES; i++) begin : g_page
      always_ff @(posedge sck or negedge rst_n) begin
         if (!rst_n) begin
            page_buf[i] <= 8'h00;
         end else if (byte_done && byte_idx == 2'h2 && !link_blocked &&
                      col == epw_pkg::COL_W'(i)) begin
            page_buf[i] <= next_shift;  // R01 buffers whole page
         end
      end
   end

   // Status read selection and status byte reload at each byte boundary
   always_ff @(posedge sck or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         status_read_cmd_active <= 1'b0;
         out_shift   <= 8'h00;
      end else if (byte_done) begin
         if (byte_idx == 2'h0) begin
            status_read_cmd_active <= (next_shift == epw_pkg::OP_STATUS_READ);
         end
         // R09 busy in bit 0
         out_shift <= {4'h0, status_s};
      end
   end

   // Serial output changes on the falling edge, most significant bit first
   always_ff @(negedge sck or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         so    <= 1'b0;
         so_oe <= 1'b0;
      end else begin
         so_oe <= status_read_cmd_active;
         so    <= status_read_cmd_active & out_shift[~bit_cnt];
      end
   end

   // ---------------- Reference clock domain ----------------
   logic [1:0]                      pin_s;
   logic                            cs_s;
   logic                            wp_s;
   logic                            cs_prev;
   logic                            frame_end;
   logic                            seen_tog;
   logic                            fresh;
   logic                            op_is_write;
   logic                            write_ok;
   epw_pkg::epw_wstate_type         state;
   epw_pkg::epw_wstate_type         next_state;
   logic [31:0]                     timer;
   logic                            timer_done;
   logic [epw_pkg::COL_W-1:0]       prog_idx;
   logic [epw_pkg::ROW_W-1:0]       prog_row;
   logic [7:0]                      prog_buf [epw_pkg::PAGE_BYTES];
   logic [epw_pkg::PAGE_BYTES-1:0]  prog_mask;
   logic [7:0]                      mem [2**epw_pkg::ADDR_W];

   // Chip select and protect pin synchroniser
   epw_sync3 #(
      .WIDTH (2),
      .INIT  (epw_pkg::PIN_SYNC_INIT)
   ) u_pin_sync (
      .clk   (ref_clk),
      .rst_n (rst_n),
      .d     ({cs_n, wp_n}),
      .q     (pin_s)
   );

   assign cs_s        = pin_s[1];
   assign wp_s        = pin_s[0];
   assign frame_end   = cs_s & ~cs_prev;
   assign fresh       = (op_tog != seen_tog);
   assign op_is_write = ((link_op & epw_pkg::OP_WRITE_MASK) == epw_pkg::OP_WRITE);
   assign timer_done  = (timer == 32'(WRITE_CYCLES - 1));

   // R08 whole-byte frame with data
   // R14 needs latch set and protect pin high
   assign write_ok = frame_end && fresh && link_aligned && op_is_write &&
                     data_seen && !link_blocked && write_enable_latch && wp_s;

   // Deselect edge detection and frame freshness tracking
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cs_prev  <= 1'b1;
         seen_tog <= 1'b0;
      end else begin
         cs_prev <= cs_s;
         if (frame_end) begin
            seen_tog <= op_tog;  // Link words are quiet once deselected
         end
      end
   end

   // Internal write cycle sequencing
   always_comb begin
      next_state = state;
      case (state)
         epw_pkg::EPW_IDLE: begin
            if (write_ok) begin
               next_state = epw_pkg::EPW_PROG;
            end
         end
         epw_pkg::EPW_PROG: begin
            if (prog_idx == 3'h7) begin
               next_state = epw_pkg::EPW_WAIT;
            end
         end
         epw_pkg::EPW_WAIT: begin
            if (timer_done) begin
               next_state = epw_pkg::EPW_IDLE;
            end
         end
         default: begin
            next_state = epw_pkg::EPW_IDLE;
         end
      endcase
   end

   // State register and busy flag
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state           <= epw_pkg::EPW_IDLE;
         ready_busy_flag <= 1'b0;
      end else begin
         state <= next_state;
         // R09 flag follows the cycle
         ready_busy_flag <= (next_state != epw_pkg::EPW_IDLE);
      end
   end

   // Write cycle timer, counted from the start of the cycle
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         timer <= 32'h0000_0000;
      end else if (state == epw_pkg::EPW_IDLE) begin
         timer <= 32'h0000_0000;
      end else if (!timer_done) begin
         timer <= timer + 32'h0000_0001;  // R16 bounded duration
      end
   end

   // Page snapshot at cycle start, so a following frame cannot disturb it
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         prog_row  <= '0;
         prog_mask <= '0;
         prog_idx  <= '0;
      end else if (state == epw_pkg::EPW_IDLE) begin
         prog_idx <= '0;
         if (write_ok) begin
            prog_row  <= link_row;
            prog_mask <= page_mask;
         end
      end else if (state == epw_pkg::EPW_PROG) begin
         prog_idx <= prog_idx + 3'h1;
      end
   end

   // Snapshot data, one entry per column
   for (genvar i = 0; i < epw_pkg::PAGE_BYTES; i++) begin : g_snap
      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            prog_buf[i] <= 8'h00;
         end else if (state == epw_pkg::EPW_IDLE && write_ok) begin
            prog_buf[i] <= page_buf[i];
         end
      end
   end

   // Array programming, one byte per clock, only received bytes
   always_ff @(posedge ref_clk) begin
      // R01 one cycle for the page
      if (state == epw_pkg::EPW_PROG && prog_mask[prog_idx]) begin
         mem[{prog_row, prog_idx}] <= prog_buf[prog_idx];
      end
   end

   // Array read-back port
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_rd_data <= 8'h00;
      end else begin
         mem_rd_data <= mem[mem_rd_addr];
      end
   end

   // Write enable latch
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         write_enable_latch <= 1'b0;
      end else if (state == epw_pkg::EPW_WAIT && timer_done) begin
         // R07 cleared at completion
         write_enable_latch <= 1'b0;
      end else if (frame_end && fresh && link_aligned && !link_blocked &&
                   state == epw_pkg::EPW_IDLE) begin
         // R13 set at deselect
         if (link_op == epw_pkg::OP_SET_WRITE_LATCH) begin
            write_enable_latch <= 1'b1;
         end else if (link_op == epw_pkg::OP_CLEAR_WRITE_LATCH) begin
            write_enable_latch <= 1'b0;
         end
      end
   end

endmodule

// [epw_core_sva.sv]
// Port-level assertion checker for the page-write EEPROM core
`timescale 1ns/1ps
module epw_core_sva #(
   parameter int WRITE_CYCLES = 40
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic wp_n,
   input wire logic so,
   input wire logic so_oe,
   input wire logic ready_busy_flag,
   input wire logic write_enable_latch
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   int busy_cnt;

   // Counts the cycles the busy flag has stood high
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_cnt <= 0;
      end else if (ready_busy_flag) begin
         busy_cnt <= busy_cnt + 1;
      end else begin
         busy_cnt <= 0;
      end
   end

   // Chip select has been high for a while
   sequence s_deselected;
      cs_n && $past(cs_n, 2);
   endsequence
   // Busy covers at least the page programming slots
   sequence s_hold;
      ready_busy_flag [*8];
   endsequence

   property p_busy_len;
      $fell(ready_busy_flag) |-> busy_cnt == WRITE_CYCLES;
   endproperty
   a_busy_len: assert property (p_busy_len) else $error("busy time wrong");
   property p_busy_hold;
      $rose(ready_busy_flag) |-> s_hold;
   endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
   property p_done_clear;
      $fell(ready_busy_flag) |-> !write_enable_latch;
   endproperty
   a_done_clear: assert property (p_done_clear) else $error("latch kept at end");
   property p_start_frame;
      $rose(ready_busy_flag) |-> s_deselected;
   endproperty
   a_start_frame: assert property (p_start_frame) else $error("busy inside frame");
   property p_start_gate;
      $rose(ready_busy_flag) |-> write_enable_latch && wp_n;
   endproperty
   a_start_gate: assert property (p_start_gate) else $error("write not gated");
   property p_busy_no_set;
      ready_busy_flag |=> !$rose(write_enable_latch);
   endproperty
   a_busy_no_set: assert property (p_busy_no_set) else $error("set while busy");
   property p_busy_keep;
      ready_busy_flag && write_enable_latch |=> write_enable_latch || !ready_busy_flag;
   endproperty
   a_busy_keep: assert property (p_busy_keep) else $error("cleared while busy");
   property p_set_frame;
      $rose(write_enable_latch) |-> s_deselected;
   endproperty
   a_set_frame: assert property (p_set_frame) else $error("latch set in frame");
   property p_oe_frame;
      cs_n |-> !so_oe;
   endproperty
   a_oe_frame: assert property (p_oe_frame) else $error("output on when idle");
   property p_so_quiet;
      !so_oe |-> !so;
   endproperty
   a_so_quiet: assert property (p_so_quiet) else $error("data while undriven");
endmodule

bind epw_core epw_core_sva #(.WRITE_CYCLES(WRITE_CYCLES)) u_sva (
   .ref_clk            (ref_clk),
   .rst_n              (rst_n),
   .cs_n               (cs_n),
   .wp_n               (wp_n),
   .so                 (so),
   .so_oe              (so_oe),
   .ready_busy_flag    (ready_busy_flag),
   .write_enable_latch (write_enable_latch)
);

// [epw_master.sv]
// Serial bus master model driving the EEPROM link in mode 0
`timescale 1ns/1ps
module epw_master (
   output logic      sck,
   output logic      cs_n,
   output logic      si,
   input  wire logic so
);
   logic [7:0] rx;

   // Idle bus, clock stands still low
   initial begin
      sck  = 1'b0;
      cs_n = 1'b1;
      si   = 1'b0;
   end

   // One framed transfer, MSB first, reply captured on rising edges
   // opcode frames
   task automatic frame(input logic [7:0] b[$], input int drop = 0);
      cs_n = 1'b0;
      foreach (b[i]) begin
         for (int k = 7; k >= 0; k--) begin
            if (i == b.size() - 1 && k < drop) break;  // Cut frame, last bits left out
            si = b[i][k];
            #80 sck = 1'b1;
            rx = {rx[6:0], so};
            #80 sck = 1'b0;
         end
      end
      #40 cs_n = 1'b1;
      si = ~si; // Released line shows no stale level
      #400;
   endtask
endmodule

// [epw_pkg.sv]
// Constants and types shared by the page-write EEPROM core
package epw_pkg;

   // Instruction codes, the write code masks out the ninth address bit
   localparam logic [7:0] OP_SET_WRITE_LATCH   = 8'h06;
   localparam logic [7:0] OP_CLEAR_WRITE_LATCH = 8'h04;
   localparam logic [7:0] OP_STATUS_READ       = 8'h05;
   localparam logic [7:0] OP_WRITE             = 8'h02;
   localparam logic [7:0] OP_WRITE_MASK        = 8'hF7;
   localparam int         OP_A8_POS            = 3;

   // Array and page geometry
   localparam int ADDR_W     = 9;
   localparam int COL_W      = 3;
   localparam int PAGE_BYTES = 8;
   localparam int ROW_W      = ADDR_W - COL_W;

   // Status byte layout and reset values
   localparam int         STATUS_BUSY_BIT = 0;
   localparam int         STATUS_WEL_BIT  = 1;
   localparam int         STATUS_BP_LSB   = 2;
   localparam logic [1:0] PIN_SYNC_INIT   = 2'h3;
   localparam logic [3:0] STAT_SYNC_INIT  = 4'h0;

   // Write cycle time and its count at the reference clock, rounded down
   localparam int CLK_FREQ_HZ         = 20000000;
   localparam int WRITE_CYCLE_TIME_US = 5000;
   localparam int WRITE_CYCLE_CYCLES  = WRITE_CYCLE_TIME_US * (CLK_FREQ_HZ / 1000000);

   // Internal write cycle states
   typedef enum logic [2:0] {
      EPW_IDLE = 3'b001,
      EPW_PROG = 3'b010,
      EPW_WAIT = 3'b100
   } epw_wstate_type;

endpackage

// [epw_sync3.sv]
// Three-stage synchroniser; a change passes once stages two and three agree
`timescale 1ns/1ps
module epw_sync3 #(
   parameter int               WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT  = '0
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   // Sampling chain
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= INIT;
         stage2 <= INIT;
         stage3 <= INIT;
      end else begin
         stage1 <= d;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // Agreement filter, one per bit
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            q[i] <= INIT[i];
         end else if (stage2[i] == stage3[i]) begin
            q[i] <= stage3[i];
         end
      end
   end

endmodule

// [tb_epw_core.sv]
// Self-checking bench for the page-write EEPROM core
`timescale 1ns/1ps
module tb_epw_core;
   typedef struct {string name; logic [7:0] val;} epw_note_type;
   logic ref_clk, rst_n, wp_n, sck, cs_n, si, so, so_oe, ready_busy_flag, write_enable_latch;
   logic [1:0] block_protect_level;
   logic [8:0] mem_rd_addr;
   logic [7:0] mem_rd_data, obs;
   logic oe_hit;
   logic [7:0] exp_mem [0:511];
   epw_note_type exp_q[$];
   event got_ev;
   int n_mismatch, checks, cyc;
   int seed;

   epw_master u_mst (.sck(sck), .cs_n(cs_n), .si(si), .so(so));
   epw_core #(.WRITE_CYCLES(200)) DUT (
      .ref_clk(ref_clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n),
      .block_protect_level(block_protect_level), .mem_rd_addr(mem_rd_addr), .so(so),
      .so_oe(so_oe), .ready_busy_flag(ready_busy_flag),
      .write_enable_latch(write_enable_latch), .mem_rd_data(mem_rd_data));

   // Clock and hang guard
   always #25 ref_clk = ~ref_clk;
   // Notes any drive of the serial output
   always @(posedge so_oe) oe_hit = 1'b1;
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 10000) begin
         n_mismatch++;
         stop_test();
      end
   end

   task automatic note(input string name, input logic [7:0] v);
      exp_q.push_back('{name, v});
   endtask
   task automatic show(input logic [7:0] v);
      obs = v;
      -> got_ev;
      #1;
   endtask
   // Watcher pairs each result with the oldest note
   always @(got_ev) begin
      epw_note_type e;
      e = exp_q.pop_front();
      checks++;
      if (obs !== e.val) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", e.name, e.val, obs);
      end
   end
   task automatic flag(input string name, input logic g, input logic e);
      note(name, {7'h0, e});
      show({7'h0, g});
   endtask
   task automatic status(input logic [7:0] e);
      oe_hit = 1'b0;
      u_mst.frame('{8'h05, 8'h00});
      note("status", e);
      show(u_mst.rx);
      flag("oe", oe_hit, 1'b1);
   endtask
   task automatic poll(output int n);
      n = 0;
      do begin
         u_mst.frame('{8'h05, 8'h00});
         n++;
      end while (u_mst.rx[0] !== 1'b0 && n < 20);
      flag("ready", u_mst.rx[0], 1'b0);
   endtask
   // Enable then page write; go keeps the expected array in step
   task automatic page(input logic [8:0] a, input int n, input logic go);
      logic [7:0] b[$];
      logic [7:0] d;
      b = '{{4'h0, a[8], 3'h2}, a[7:0]};
      for (int i = 0; i < n; i++) begin
         d = 8'($random(seed));
         b.push_back(d);
         if (go) exp_mem[{a[8:3], a[2:0] + 3'(i)}] = d;
      end
      u_mst.frame('{8'h06});
      u_mst.frame(b);
   endtask
   task automatic readback(input logic [8:0] a);
      for (int c = 0; c < 8; c++) begin
         @(posedge ref_clk);
         #5 mem_rd_addr = {a[8:3], 3'(c)};
         repeat (2) @(posedge ref_clk);
         #5 note("mem", exp_mem[{a[8:3], 3'(c)}]);
         show(mem_rd_data);
      end
   endtask
   task automatic stop_test();
      $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      int n;
      logic [8:0] a;
      ref_clk = 1'b0;
      rst_n = 1'b0;
      wp_n = 1'b1;
      block_protect_level = 2'h0;
      mem_rd_addr = 9'h000;
      oe_hit = 1'b0;
      seed = 32'h2504;
      repeat (4) @(posedge ref_clk);
      #5 rst_n = 1'b1;
      repeat (4) @(posedge ref_clk);
      u_mst.frame('{8'h02, 8'h10, 8'h5A});
      flag("busy", ready_busy_flag, 1'b0);
      flag("oe", oe_hit, 1'b0);
      a = 9'($random(seed));
      a[2:0] = 3'h5;
      page(a, 10, 1'b1);
      status(8'h03);
      u_mst.frame('{8'h04});
      flag("wel", write_enable_latch, 1'b1);
      poll(n);
      flag("poll", n > 1, 1'b1);
      flag("wel", write_enable_latch, 1'b0);
      readback(a);
      a[2:0] = 3'h5;
      page(a, 3, 1'b1);
      poll(n);
      readback(a);
      @(posedge ref_clk);
      #5 wp_n = 1'b0;
      page(a, 2, 1'b0);
      flag("busy", ready_busy_flag, 1'b0);
      readback(a);
      @(posedge ref_clk);
      #5 wp_n = 1'b1;
      u_mst.frame('{8'h02, 8'h20, 8'hA5, 8'h5A}, 3);
      flag("busy", ready_busy_flag, 1'b0);
      u_mst.frame('{8'h02, 8'h20});
      flag("busy", ready_busy_flag, 1'b0);
      flag("wel", write_enable_latch, 1'b1);
      block_protect_level = 2'($random(seed));
      u_mst.frame('{8'h04});
      status({4'h0, block_protect_level, 2'h0});
      stop_test();
   end
endmodule
